// >>> design/serial_rx_duplex.sv
// 8-bit clocked serial receive and transmit/receive engine with APB registers
// Functional notes
// - receive mode shifts input bits in LSB first on the serial clock after start
// - after eight bits the byte goes to the data buffer with a buffer-full interrupt
// - internal clock receive halts the clock until software reads the buffer
// - external clock shifts on every rising edge, never waits; software must keep up
// - start cleared: finish current byte, store it, then clear busy
// - inhibit set aborts reception at once and clears busy
// - mode change loses buffer; software stops and reads before switching
// - duplex drives output on falling edge, samples input on rising edge, LSB first
// - duplex stores received byte and interrupts; software reads before writing next
// - internal clock duplex stalls until byte read and next byte written
// - at start, output keeps previous last bit until first falling edge
// - duplex start cleared: continue until byte stored, then clear busy
// - duplex inhibit aborts both directions immediately and clears busy
// - after ending with start cleared, last bit holds past last rising edge
// - status bit 3 reads busy while a transfer is in progress
// - clock source 111 uses the peer clock pin, otherwise clock generated internally
`timescale 1ns/1ps
module serial_rx_duplex #(
    parameter logic [15:0] DIV_BASE = serial_rx_duplex_pkg::DIV_BASE_DEFAULT
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serialClockIn,
    output logic             serialClockOut,
    output logic             serialClockOe,
    input  wire logic        serialInput,
    output logic             serialOutput,
    output logic             serialBufferIrq
);
    typedef enum logic [2:0] {
        IDLE  = 3'b001,
        SHIFT = 3'b010,
        HOLD  = 3'b100
    } state_e;

    state_e      state_q, state_d;
    logic        start_q, start_d;
    logic        inhibit_q, inhibit_d;
    logic [1:0]  mode_q, mode_d;
    logic [2:0]  sckSel_q, sckSel_d;
    logic [7:0]  dataBuf_q, dataBuf_d;
    logic        bufFull_q, bufFull_d;
    logic        txLoaded_q, txLoaded_d;
    logic [7:0]  shift_q, shift_d;
    logic [2:0]  bitCnt_q, bitCnt_d;
    logic [15:0] divCnt_q, divCnt_d;
    logic        sckOut_q, sckOut_d;
    logic        sckOe_q, sckOe_d;
    logic        so_q, so_d;
    logic        irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [2:0]  clkSync_q;
    logic [2:0]  dinSync_q;
    logic        clkLvl_q, clkLvl_d;
    logic        dinLvl_q, dinLvl_d;
    logic        clkPrev_q;

    logic        external;
    logic        accessEn;
    logic        wrCtrl;
    logic        wrData;
    logic        rdData;
    logic        tick;
    logic        fallEv;
    logic        riseEv;
    logic        byteDone;
    logic        ready;
    logic [15:0] halfCount;
    logic [7:0]  statusByte;

    always_comb begin
        state_d    = state_q;
        start_d    = start_q;
        inhibit_d  = inhibit_q;
        mode_d     = mode_q;
        sckSel_d   = sckSel_q;
        dataBuf_d  = dataBuf_q;
        bufFull_d  = bufFull_q;
        txLoaded_d = txLoaded_q;
        shift_d    = shift_q;
        bitCnt_d   = bitCnt_q;
        divCnt_d   = divCnt_q;
        sckOut_d   = sckOut_q;
        so_d       = so_q;
        irq_d      = 1'b0;
        prdata_d   = prdata_q;
        pslverr_d  = pslverr_q;
        pready_d   = psel && !penable;
        external   = (sckSel_q == serial_rx_duplex_pkg::SCK_EXTERNAL);
        sckOe_d    = !external;
        // a level change counts once the second and third stages agree
        clkLvl_d   = (clkSync_q[1] == clkSync_q[2]) ? clkSync_q[1] : clkLvl_q;
        dinLvl_d   = (dinSync_q[1] == dinSync_q[2]) ? dinSync_q[1] : dinLvl_q;
        accessEn   = psel && penable && pready_q;
        wrCtrl     = accessEn && pwrite && (paddr == serial_rx_duplex_pkg::CTRL_OFFSET);
        wrData     = accessEn && pwrite && (paddr == serial_rx_duplex_pkg::DATA_OFFSET);
        rdData     = accessEn && !pwrite && (paddr == serial_rx_duplex_pkg::DATA_OFFSET);
        halfCount  = DIV_BASE << sckSel_q;
        tick       = 1'b0;

        // serial clock: internal divider or detected peer edges
        if (state_q == SHIFT && !external) begin
            if (divCnt_q >= halfCount - 16'h0001) begin
                divCnt_d = 16'h0000;
                tick     = 1'b1;
                sckOut_d = !sckOut_q;
            end else begin
                divCnt_d = divCnt_q + 16'h0001;
            end
        end
        if (external) begin
            fallEv = (state_q == SHIFT) && clkPrev_q && !clkLvl_q;
            riseEv = (state_q == SHIFT) && !clkPrev_q && clkLvl_q;
        end else begin
            fallEv = tick && sckOut_q;
            riseEv = tick && !sckOut_q;
        end
        byteDone = riseEv && (bitCnt_q == 3'(serial_rx_duplex_pkg::BYTE_BITS - 1));

        // software side effects first so hardware sets win in the same cycle
        if (rdData) begin
            bufFull_d = 1'b0;
        end
        if (wrData) begin
            dataBuf_d = pwdata[7:0];
        end

        // output changes only on a falling edge; last bit holds otherwise
        if (fallEv && mode_q != serial_rx_duplex_pkg::MODE_RX) begin
            if (bitCnt_q == 3'h0) begin
                shift_d    = dataBuf_q;
                so_d       = dataBuf_q[0];
                txLoaded_d = 1'b0;
                irq_d      = (mode_q == serial_rx_duplex_pkg::MODE_TX);
            end else begin
                so_d = shift_q[0];
            end
        end
        if (riseEv) begin
            shift_d  = {dinLvl_q, shift_q[7:1]};
            bitCnt_d = bitCnt_q + 3'h1;
        end
        if (byteDone) begin
            if (mode_q != serial_rx_duplex_pkg::MODE_TX) begin
                dataBuf_d = {dinLvl_q, shift_q[7:1]};
                bufFull_d = 1'b1;
                irq_d     = 1'b1;
            end
            if (!start_q) begin
                state_d = IDLE;
            end else if (!external) begin
                state_d = HOLD;
            end
            // external clock keeps shifting without a pause
        end

        // leave the wait once software has serviced the buffer
        case (mode_q)
            serial_rx_duplex_pkg::MODE_RX:   ready = !bufFull_q;
            serial_rx_duplex_pkg::MODE_TXRX: ready = !bufFull_q && txLoaded_q;
            default:                         ready = txLoaded_q;
        endcase
        if (state_q == HOLD) begin
            if (!start_q) begin
                state_d = IDLE;
            end else if (ready) begin
                state_d  = SHIFT;
                divCnt_d = 16'h0000;
            end
        end

        if (wrData) begin
            txLoaded_d = 1'b1;
        end

        if (wrCtrl) begin
            start_d   = pwdata[serial_rx_duplex_pkg::START_POS];
            inhibit_d = pwdata[serial_rx_duplex_pkg::INHIBIT_POS];
            mode_d    = pwdata[serial_rx_duplex_pkg::MODE_POS +: 2];
            sckSel_d  = pwdata[serial_rx_duplex_pkg::SCK_POS +: 3];
            if (mode_d != mode_q) begin
                dataBuf_d  = serial_rx_duplex_pkg::DATA_RESET;
                bufFull_d  = 1'b0;
                txLoaded_d = 1'b0;
            end
            if (inhibit_d) begin
                state_d  = IDLE;
                start_d  = 1'b0;
                bitCnt_d = 3'h0;
                divCnt_d = 16'h0000;
                sckOut_d = 1'b1;
                irq_d    = 1'b0;
            end else if (start_d && state_q == IDLE) begin
                state_d  = SHIFT;
                bitCnt_d = 3'h0;
                divCnt_d = 16'h0000;
                sckOut_d = 1'b1;
            end
        end

        statusByte = serial_rx_duplex_pkg::STATUS_ONES;
        statusByte[serial_rx_duplex_pkg::BUSY_POS]     = (state_q != IDLE);
        statusByte[serial_rx_duplex_pkg::SHIFTING_POS] = (state_q == SHIFT);
        if (psel && !penable) begin
            pslverr_d = 1'b0;
            unique case (paddr)
                serial_rx_duplex_pkg::CTRL_OFFSET:
                    prdata_d = {24'h00_0000, start_q, inhibit_q, mode_q, 1'b0, sckSel_q};
                serial_rx_duplex_pkg::DATA_OFFSET:
                    prdata_d = {24'h00_0000, dataBuf_q};
                serial_rx_duplex_pkg::STATUS_OFFSET:
                    prdata_d = {24'h00_0000, statusByte};
                default: begin
                    prdata_d  = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        clkSync_q <= {clkSync_q[1:0], serialClockIn};
        dinSync_q <= {dinSync_q[1:0], serialInput};
        if (sys_rst) begin
            state_q    <= IDLE;
            start_q    <= 1'b0;
            inhibit_q  <= 1'b0;
            mode_q     <= serial_rx_duplex_pkg::MODE_RESET;
            sckSel_q   <= serial_rx_duplex_pkg::SCK_RESET;
            dataBuf_q  <= serial_rx_duplex_pkg::DATA_RESET;
            bufFull_q  <= 1'b0;
            txLoaded_q <= 1'b0;
            shift_q    <= 8'h00;
            bitCnt_q   <= 3'h0;
            divCnt_q   <= 16'h0000;
            sckOut_q   <= 1'b1;
            sckOe_q    <= 1'b1;
            so_q       <= 1'b1;
            irq_q      <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            clkLvl_q   <= 1'b1;
            dinLvl_q   <= 1'b0;
            clkPrev_q  <= 1'b1;
        end else begin
            state_q    <= state_d;
            start_q    <= start_d;
            inhibit_q  <= inhibit_d;
            mode_q     <= mode_d;
            sckSel_q   <= sckSel_d;
            dataBuf_q  <= dataBuf_d;
            bufFull_q  <= bufFull_d;
            txLoaded_q <= txLoaded_d;
            shift_q    <= shift_d;
            bitCnt_q   <= bitCnt_d;
            divCnt_q   <= divCnt_d;
            sckOut_q   <= sckOut_d;
            sckOe_q    <= sckOe_d;
            so_q       <= so_d;
            irq_q      <= irq_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            clkLvl_q   <= clkLvl_d;
            dinLvl_q   <= dinLvl_d;
            clkPrev_q  <= clkLvl_q;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign serialClockOut  = sckOut_q;
    assign serialClockOe   = sckOe_q;
    assign serialOutput    = so_q;
    assign serialBufferIrq = irq_q;

    a_lsb_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
        riseEv |=> shift_q == {$past(dinLvl_q), $past(shift_q[7:1])})
        else $error("received bit not shifted in at the top");
    a_byte_store: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (byteDone && mode_q != serial_rx_duplex_pkg::MODE_TX && !wrCtrl) |=> bufFull_q && serialBufferIrq)
        else $error("completed byte not stored with interrupt");
    a_wait_stall: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == HOLD) |-> (serialClockOut && !riseEv && !fallEv))
        else $error("serial clock moved during wait");
    a_ext_nowait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (external && state_q == SHIFT && !wrCtrl) |=> state_q != HOLD)
        else $error("external clock entered a wait");
    a_stop_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (byteDone && !start_q) |=> state_q == IDLE &&
            (bufFull_q || $past(wrCtrl) || mode_q == serial_rx_duplex_pkg::MODE_TX))
        else $error("transfer did not end after start cleared");
    a_inhibit_abort: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wrCtrl && pwdata[serial_rx_duplex_pkg::INHIBIT_POS]) |=> state_q == IDLE && !serialBufferIrq)
        else $error("inhibit did not abort at once");
    a_mode_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wrCtrl && pwdata[serial_rx_duplex_pkg::MODE_POS +: 2] != mode_q) |=> !bufFull_q)
        else $error("buffer kept across mode change");
    a_out_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !fallEv |=> $stable(serialOutput))
        else $error("serial output changed off a falling edge");
    a_irq_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
        serialBufferIrq |=> !serialBufferIrq)
        else $error("interrupt longer than one cycle");
    a_clock_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 (serialClockOe == !$past(external)))
        else $error("clock pin enable disagrees with source select");
endmodule

// >>> design/serial_rx_duplex_pkg.sv
// constants for the clocked serial receive / duplex block
package serial_rx_duplex_pkg;
    // register byte offsets on the APB
    localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
    localparam logic [7:0]  DATA_OFFSET      = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET    = 8'h08;
    // control register field positions
    localparam int          START_POS        = 7;
    localparam int          INHIBIT_POS      = 6;
    localparam int          MODE_POS         = 4;
    localparam int          SCK_POS          = 0;
    // status register field positions
    localparam int          BUSY_POS         = 3;
    localparam int          SHIFTING_POS     = 2;
    // transfer mode codes
    localparam logic [1:0]  MODE_TX          = 2'h0;
    localparam logic [1:0]  MODE_TXRX        = 2'h2;
    localparam logic [1:0]  MODE_RX          = 2'h3;
    // clock source codes
    localparam logic [2:0]  SCK_EXTERNAL     = 3'h7;
    // reset values
    localparam logic [1:0]  MODE_RESET       = MODE_TX;
    localparam logic [2:0]  SCK_RESET        = 3'h0;
    localparam logic [7:0]  DATA_RESET       = 8'h00;
    localparam logic [7:0]  STATUS_ONES      = 8'hF3;
    // internal clock half period in ref_clk cycles for clock select 0
    localparam logic [15:0] DIV_BASE_DEFAULT = 16'h0002;
    localparam int          BYTE_BITS        = 8;
endpackage

// >>> sim/serial_peer_model.sv
// serial peer model: offers bytes on the data line and captures what the device shifts out
`timescale 1ns/1ps
module serial_peer_model (
    input  wire logic       lineClk,
    input  wire logic       frameStart,
    input  wire logic       extRun,
    input  wire logic       devOut,
    input  wire logic [7:0] sendByte,
    output logic            peerClk,
    output logic            peerData,
    output logic      [7:0] gotByte,
    output int              bitIdx
);
    initial begin
        peerClk = 1'b1;
        peerData = 1'b0;
        gotByte = 8'h00;
        bitIdx = 8;
    end
    // link clock runs only inside a frame, idles high, phase unrelated to ref_clk
    always @(posedge extRun) begin
        #13;
        repeat (8) begin
            #200 peerClk = 1'b0;
            #200 peerClk = 1'b1;
        end
    end
    always @(posedge frameStart) bitIdx = 0;
    // next bit offered on the falling edge, lsb first
    always @(negedge lineClk) begin
        if (bitIdx < 8) peerData = sendByte[bitIdx];
    end
    always @(posedge lineClk) begin
        if (bitIdx < 8) begin
            gotByte[bitIdx] = devOut;
            bitIdx++;
            // line released well after the last rising edge: no pull, so show the inverse once
            if (bitIdx == 8) peerData <= #300 ~sendByte[7];
        end
    end
endmodule

// >>> sim/tb.sv
// self-checking bench for the clocked serial receive / duplex block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
    localparam logic [7:0] CTL = serial_rx_duplex_pkg::CTRL_OFFSET;
    localparam logic [7:0] DAT = serial_rx_duplex_pkg::DATA_OFFSET;
    localparam logic [7:0] STS = serial_rx_duplex_pkg::STATUS_OFFSET;
    logic        ref_clk, sys_rst, psel, penable, pwrite, frameStart, extRun;
    logic [7:0]  paddr, sendByte, gotByte, txByte, exp8;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, clkOut, clkOe, dataIn, dataOut, irq, peerClk, slv, prevBit;
    wire         lineClk = clkOe ? clkOut : peerClk;
    int          err_total, checked, irqCount, bitIdx, seed;
    logic [7:0]  expQ[$];

    serial_rx_duplex #(.DIV_BASE(16'h0008)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialClockIn(peerClk), .serialClockOut(clkOut), .serialClockOe(clkOe),
        .serialInput(dataIn), .serialOutput(dataOut), .serialBufferIrq(irq));
    serial_peer_model peer (
        .lineClk(lineClk), .frameStart(frameStart), .extRun(extRun), .devOut(dataOut),
        .sendByte(sendByte), .peerClk(peerClk), .peerData(dataIn), .gotByte(gotByte), .bitIdx(bitIdx));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (irq === 1'b1) irqCount++;
    end

    task automatic wrap_up();
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic frame(input logic [7:0] b);
        expQ.push_back(b);
        @(posedge ref_clk);
        sendByte <= b;
        frameStart <= 1'b1;
        @(posedge ref_clk);
        frameStart <= 1'b0;
    endtask
    task automatic waitIrq(input int target);
        int k;
        for (k = 0; k < 4000 && irqCount < target; k++) @(posedge ref_clk);
        `CHK("irqCount", target, irqCount)
    endtask
    task automatic waitIdle();
        int k;
        rd = 32'hffff_ffff;
        for (k = 0; k < 60 && rd[3] !== 1'b0; k++) apb(1'b0, STS, 32'h0000_0000);
        `CHK("busyEnd", 1'b0, rd[3])
    endtask
    task automatic rxCheck();
        apb(1'b0, DAT, 32'h0000_0000);
        exp8 = expQ.pop_front();
        `CHK("rxByte", exp8, rd[7:0])
    endtask

    initial begin
        {sys_rst, psel, penable, pwrite, frameStart, extRun} = 6'h20;
        {paddr, sendByte, pwdata} = '0;
        {err_total, checked, irqCount} = '0;
        seed = 32'h749e;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, CTL, 32'h0000_0000);
        `CHK("ctrlReset", 32'h0000_0000, rd)
        apb(1'b0, STS, 32'h0000_0000);
        `CHK("statusReset", 32'h0000_00f3, rd)
        apb(1'b0, 8'h0c, 32'h0000_0000);
        `CHK("unmapped", 1'b1, slv)
        // receive, internal clock: wait state, then clear start in mid byte
        apb(1'b1, CTL, 32'h0000_0030);
        `CHK("sckOe", 1'b1, clkOe)
        frame(8'($random(seed)));
        apb(1'b1, CTL, 32'h0000_00b0);
        apb(1'b0, STS, 32'h0000_0000);
        `CHK("busy", 1'b1, rd[3])
        waitIrq(1);
        repeat (40) @(posedge ref_clk);
        `CHK("sckHalt", 1'b1, clkOut)
        frame(8'($random(seed)));
        rxCheck();
        repeat (20) @(posedge ref_clk);
        apb(1'b1, CTL, 32'h0000_0030);
        waitIrq(2);
        waitIdle();
        rxCheck();
        // duplex, internal clock, two bytes with a wait state between
        apb(1'b1, CTL, 32'h0000_0020);
        txByte = 8'($random(seed));
        apb(1'b1, DAT, {24'h00_0000, txByte});
        frame(8'($random(seed)));
        apb(1'b1, CTL, 32'h0000_00a0);
        waitIrq(3);
        `CHK("txBits", txByte, gotByte)
        rxCheck();
        repeat (40) @(posedge ref_clk);
        `CHK("sckStall", 1'b1, clkOut)
        frame(8'($random(seed)));
        txByte = 8'($random(seed));
        apb(1'b1, DAT, {24'h00_0000, txByte});
        repeat (20) @(posedge ref_clk);
        apb(1'b1, CTL, 32'h0000_0020);
        waitIrq(4);
        `CHK("txBits2", txByte, gotByte)
        waitIdle();
        rxCheck();
        `CHK("lastBit", txByte[7], dataOut)
        // duplex start then abort by inhibit
        prevBit = txByte[7];
        txByte = 8'($random(seed));
        apb(1'b1, DAT, {24'h00_0000, txByte});
        apb(1'b1, CTL, 32'h0000_00a0);
        repeat (4) @(posedge ref_clk);
        `CHK("holdBit", prevBit, dataOut)
        repeat (30) @(posedge ref_clk);
        apb(1'b1, CTL, 32'h0000_0060);
        apb(1'b0, STS, 32'h0000_0000);
        `CHK("abortBusy", 1'b0, rd[3])
        repeat (40) @(posedge ref_clk);
        `CHK("noIrq", 4, irqCount)
        // receive on the peer clock
        apb(1'b1, CTL, 32'h0000_0037);
        repeat (2) @(posedge ref_clk);
        `CHK("sckOeExt", 1'b0, clkOe)
        frame(8'($random(seed)));
        apb(1'b1, CTL, 32'h0000_00b7);
        @(posedge ref_clk);
        extRun <= 1'b1;
        @(posedge ref_clk);
        extRun <= 1'b0;
        waitIrq(5);
        rxCheck();
        // duplex on the peer clock: buffer serviced before the peer starts shifting
        apb(1'b1, CTL, 32'h0000_0077);
        apb(1'b0, STS, 32'h0000_0000);
        `CHK("extAbort", 1'b0, rd[3])
        apb(1'b1, CTL, 32'h0000_0027);
        txByte = 8'($random(seed));
        apb(1'b1, DAT, {24'h00_0000, txByte});
        frame(8'($random(seed)));
        apb(1'b1, CTL, 32'h0000_00a7);
        @(posedge ref_clk);
        extRun <= 1'b1;
        @(posedge ref_clk);
        extRun <= 1'b0;
        waitIrq(6);
        rxCheck();
        wrap_up();
    end
endmodule
